/* File: bench/pcs_i2c_host_model.sv */
`timescale 1ns/1ps
// ==========
// serial host: 4 clocks per half bit, well above the 2 the slave needs
module pcs_i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h20
) (
  input wire logic sys_clk, // system clock
  output logic scl, // serial clock, host driven
  output logic sda_low, // high while pulling data low
  input wire logic sda_line // resolved data wire
);
  // idle bus, data left to the pull-up
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_clk
  task automatic start_cond();
    sda_low <= 1'h0;
    wait_clk(2);
    scl <= 1'h1;
    wait_clk(4);
    sda_low <= 1'h1;
    wait_clk(4);
    scl <= 1'h0;
    wait_clk(2);
  endtask : start_cond
  task automatic stop_cond();
    sda_low <= 1'h1;
    wait_clk(2);
    scl <= 1'h1;
    wait_clk(4);
    sda_low <= 1'h0;
    wait_clk(4);
  endtask : stop_cond
  // data only moves while the clock is low
  task automatic bit_xfer(input logic b, output logic s);
    sda_low <= !b;
    wait_clk(2);
    scl <= 1'h1;
    wait_clk(4);
    s = sda_line;
    scl <= 1'h0;
    wait_clk(2);
  endtask : bit_xfer
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], s);
    end
    bit_xfer(1'h1, s);
    ack = !s;
  endtask : write_byte
  // single byte reads always end with a nack
  task automatic read_byte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'h1, d[i]);
    end
    bit_xfer(1'h1, s);
  endtask : read_byte
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start_cond();
    write_byte({DEV_ADDR, 1'h0}, k0);
    write_byte(a, k1);
    write_byte(d, k2);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start_cond();
    write_byte({DEV_ADDR, 1'h0}, k0);
    write_byte(a, k1);
    start_cond();
    write_byte({DEV_ADDR, 1'h1}, k2);
    read_byte(d);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask : reg_read
endmodule : pcs_i2c_host_model

/* File: bench/pcs_protection_regs_assertions.sv */
`timescale 1ns/1ps
// ==========
// port-level checks for the protection register bank
module pcs_protection_regs_assertions #(
  parameter int SOC_DLY0_CYC = 4480,
  parameter int SOC_DLY3_CYC = 560
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic scl_i, // serial clock pin
  input wire logic sda_o, // serial data drive value
  input wire logic sda_oe, // serial data drive enable
  input wire logic [4:0] protection_raw, // comparator hits
  input wire logic [7:0] phase_overcurrent_raw, // phase hits
  input wire logic [4:0] protection_enable, // per-protection enables
  input wire logic [4:0] protection_tripped, // sticky fault flags
  input wire logic [7:0] phase_overcurrent_tripped, // phase flags
  input wire logic [11:0] sum_overcurrent_limit_mv, // sum overcurrent limit
  input wire logic [11:0] overvoltage_abs_mv, // absolute overvoltage level
  input wire logic [7:0] overvoltage_rel_pct, // relative overvoltage level
  input wire logic [7:0] undervoltage_pct, // undervoltage level
  input wire logic [7:0] overtemp_degc // over-temperature level
);
  logic [15:0] soc_cnt_reg;
  // run length of the sum overcurrent hit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      soc_cnt_reg <= 16'h0000;
    end else if (!protection_raw[2]) begin
      soc_cnt_reg <= 16'h0000;
    end else if (soc_cnt_reg != 16'hFFFF) begin
      soc_cnt_reg <= soc_cnt_reg + 16'h0001;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // serial clock seen high on two samples in a row
  sequence scl_held;
    scl_i ##1 scl_i;
  endsequence
  a_sda_open_drain: assert property (sda_o == 1'h0) else $error("data pin driven high");
  a_sda_quiet_high: assert property (scl_held |-> $stable(sda_oe)) else $error("data moved while clock high");
  a_flag_sticky: assert property ((protection_tripped & $past(protection_tripped)) == $past(protection_tripped))
    else $error("fault flag dropped");
  a_trip_has_cause: assert property (((protection_tripped & ~$past(protection_tripped) & 5'h1B) &
    ~($past(protection_raw) | $past(protection_raw, 2) | $past(protection_raw, 3))) == 5'h00) else $error("flag without hit");
  a_trip_prompt: assert property (protection_raw[3] && protection_enable[3] |-> ##[1:4] protection_tripped[3])
    else $error("over-temp flag late");
  a_soc_early: assert property ($rose(protection_tripped[2]) |-> $past(soc_cnt_reg) >= SOC_DLY3_CYC)
    else $error("sum overcurrent flag too early");
  a_soc_late: assert property (soc_cnt_reg > SOC_DLY0_CYC + 4 && protection_enable[2] |-> protection_tripped[2])
    else $error("sum overcurrent flag missing");
  a_phase_cause: assert property (((phase_overcurrent_tripped & ~$past(phase_overcurrent_tripped)) &
    ~($past(phase_overcurrent_raw) | $past(phase_overcurrent_raw, 2) | $past(phase_overcurrent_raw, 3))) == 8'h00)
    else $error("phase flag without hit");
  a_limit_step: assert property (sum_overcurrent_limit_mv % 12'h032 == 12'h000 &&
    sum_overcurrent_limit_mv >= 12'h28A && sum_overcurrent_limit_mv <= 12'hEA6) else $error("limit off grid");
  a_abs_legal: assert property (overvoltage_abs_mv inside {12'h7D0, 12'h708, 12'h898, 12'h960})
    else $error("absolute level illegal");
  a_rel_legal: assert property (overvoltage_rel_pct inside {8'h96, 8'h8C, 8'h82, 8'h78})
    else $error("relative level illegal");
  a_uv_legal: assert property (undervoltage_pct inside {8'h28, 8'h1E, 8'h32, 8'h3C})
    else $error("undervoltage level illegal");
  a_ot_legal: assert property (overtemp_degc inside {8'h96, 8'hA0, 8'hAA, 8'h8C})
    else $error("temperature level illegal");
endmodule : pcs_protection_regs_assertions

bind pcs_protection_regs pcs_protection_regs_assertions #(.SOC_DLY0_CYC(SOC_DLY0_CYC), .SOC_DLY3_CYC(SOC_DLY3_CYC))
  i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .protection_raw(protection_raw), .phase_overcurrent_raw(phase_overcurrent_raw),
  .protection_enable(protection_enable), .protection_tripped(protection_tripped),
  .phase_overcurrent_tripped(phase_overcurrent_tripped), .sum_overcurrent_limit_mv(sum_overcurrent_limit_mv),
  .overvoltage_abs_mv(overvoltage_abs_mv), .overvoltage_rel_pct(overvoltage_rel_pct),
  .undervoltage_pct(undervoltage_pct), .overtemp_degc(overtemp_degc));

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`define check(nm, ex, got) begin checks++; if ((got) !== (ex)) begin mismatches++; \
  $display("FAIL %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
  logic sys_clk, rst_n, scl, sda_low, sda_line, sda_o, sda_oe;
  logic [4:0] protection_raw, protection_enable, protection_tripped;
  logic [7:0] phase_overcurrent_raw, phase_overcurrent_tripped, overvoltage_rel_pct, undervoltage_pct, overtemp_degc;
  logic [11:0] sum_overcurrent_limit_mv, overvoltage_abs_mv;
  int mismatches, checks;
  localparam logic [11:0] ABS_TAB [4] = '{12'h7D0, 12'h708, 12'h898, 12'h960};
  localparam logic [7:0] REL_TAB [4] = '{8'h96, 8'h8C, 8'h82, 8'h78};
  localparam logic [7:0] UV_TAB [4] = '{8'h28, 8'h1E, 8'h32, 8'h3C};
  localparam logic [7:0] OT_TAB [4] = '{8'h96, 8'hA0, 8'hAA, 8'h8C};
  localparam logic [7:0] LIM_CODE [4] = '{8'h05, 8'h1F, 8'h25, 8'h3F};
  localparam logic [11:0] LIM_MV [4] = '{12'h992, 12'hEA6, 12'h79E, 12'h28A};
  // short delay counts keep the filter test brief
  pcs_protection_regs #(.SOC_DLY0_CYC(16), .SOC_DLY1_CYC(8), .SOC_DLY2_CYC(4), .SOC_DLY3_CYC(2)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .protection_raw(protection_raw), .phase_overcurrent_raw(phase_overcurrent_raw),
    .protection_enable(protection_enable), .protection_tripped(protection_tripped),
    .phase_overcurrent_tripped(phase_overcurrent_tripped), .sum_overcurrent_limit_mv(sum_overcurrent_limit_mv),
    .overvoltage_abs_mv(overvoltage_abs_mv), .overvoltage_rel_pct(overvoltage_rel_pct),
    .undervoltage_pct(undervoltage_pct), .overtemp_degc(overtemp_degc));
  pcs_i2c_host_model i_host (.sys_clk(sys_clk), .scl(scl), .sda_low(sda_low), .sda_line(sda_line));
  // open-drain data wire with pull-up
  assign sda_line = (sda_low || (sda_oe && !sda_o)) ? 1'h0 : 1'h1;
  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ==========
  // helpers
  task automatic end_of_test();
    if (mismatches == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    i_host.reg_write(a, d, ok);
    `check("write ack", 1'h1, ok)
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] ex, input string nm);
    logic [7:0] d;
    logic ok;
    i_host.reg_read(a, d, ok);
    `check("read ack", 1'h1, ok)
    `check(nm, ex, d)
  endtask : rd
  // ==========
  // scenarios
  task automatic t_reset();
    `check("enable", 5'h1F, protection_enable)
    `check("limit", 12'h898, sum_overcurrent_limit_mv)
    `check("abs", 12'h7D0, overvoltage_abs_mv)
    `check("rel", 8'h96, overvoltage_rel_pct)
    `check("uv", 8'h28, undervoltage_pct)
    `check("ot", 8'h96, overtemp_degc)
    rd(8'h23, 8'h01, "delay reset");
    for (int a = 8'h24; a <= 8'h2B; a++) rd(a[7:0], 8'h00, "reset value");
    rd(8'h40, 8'h00, "unmapped");
  endtask : t_reset
  task automatic t_decode();
    for (int c = 0; c < 4; c++) begin
      for (int o = 8'h25; o <= 8'h28; o++) wr(o[7:0], c[7:0]);
      `check("abs", ABS_TAB[c], overvoltage_abs_mv)
      `check("rel", REL_TAB[c], overvoltage_rel_pct)
      `check("uv", UV_TAB[c], undervoltage_pct)
      `check("ot", OT_TAB[c], overtemp_degc)
      wr(8'h24, LIM_CODE[c]);
      `check("limit", LIM_MV[c], sum_overcurrent_limit_mv)
    end
  endtask : t_decode
  // a locked write is acknowledged but must leave the value alone
  task automatic t_lock();
    wr(8'h25, 8'h02);
    wr(8'h00, 8'hA6);
    wr(8'h25, 8'h01);
    `check("locked abs", 12'h898, overvoltage_abs_mv)
    rd(8'h25, 8'h02, "locked reg");
    wr(8'h00, 8'h00);
    wr(8'h25, 8'h01);
    `check("unlocked abs", 12'h708, overvoltage_abs_mv)
    wr(8'h2A, 8'h1F);
    rd(8'h2A, 8'h00, "flags read only");
  endtask : t_lock
  task automatic t_faults();
    wr(8'h29, 8'h01);
    `check("enable", 5'h1E, protection_enable)
    protection_raw <= 5'h1B;
    repeat (6) @(posedge sys_clk);
    protection_raw <= 5'h00;
    repeat (6) @(posedge sys_clk);
    `check("tripped", 5'h1A, protection_tripped)
    rd(8'h2A, 8'h1A, "flags reg");
    wr(8'h29, 8'h00);
    protection_raw <= 5'h01;
    repeat (6) @(posedge sys_clk);
    protection_raw <= 5'h00;
    repeat (6) @(posedge sys_clk);
    `check("tripped", 5'h1B, protection_tripped)
  endtask : t_faults
  // the short run would trip under any shorter delay code
  task automatic t_soc();
    wr(8'h23, 8'h00);
    protection_raw <= 5'h04;
    repeat (10) @(posedge sys_clk);
    protection_raw <= 5'h00;
    repeat (6) @(posedge sys_clk);
    `check("soc short", 1'h0, protection_tripped[2])
    protection_raw <= 5'h04;
    repeat (26) @(posedge sys_clk);
    protection_raw <= 5'h00;
    repeat (4) @(posedge sys_clk);
    `check("soc long", 1'h1, protection_tripped[2])
  endtask : t_soc
  task automatic t_phase();
    phase_overcurrent_raw <= 8'hFF;
    repeat (6) @(posedge sys_clk);
    `check("phase gated", 8'h00, phase_overcurrent_tripped)
    phase_overcurrent_raw <= 8'h00;
    wr(8'h4D, 8'h01);
    phase_overcurrent_raw <= 8'h81;
    repeat (6) @(posedge sys_clk);
    phase_overcurrent_raw <= 8'h00;
    repeat (6) @(posedge sys_clk);
    `check("phase", 8'h81, phase_overcurrent_tripped)
    rd(8'h2B, 8'h81, "phase reg");
    wr(8'h4D, 8'h00);
    `check("phase off", 8'h00, phase_overcurrent_tripped)
  endtask : t_phase
  // ==========
  // main sequence
  initial begin
    rst_n = 1'h0;
    protection_raw = 5'h00;
    phase_overcurrent_raw = 8'h00;
    mismatches = 0;
    checks = 0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_decode();
    t_lock();
    t_faults();
    t_soc();
    t_phase();
    end_of_test();
  end
  // watchdog, about five times the expected run
  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    end_of_test();
  end
endmodule : testbench

/* File: hw/pcs_i2c_slave.sv */
`timescale 1ns/1ps
`include "pcs_consts.svh"
module pcs_i2c_slave import pcs_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = `PCS_I2C_ADDR
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset
  input wire logic scl_i, // serial clock level
  input wire logic sda_i, // serial data level
  output logic sda_o, // data drive value
  output logic sda_oe, // data drive enable
  output pcs_byte_t reg_addr, // register pointer
  output pcs_byte_t wr_data, // write data
  output logic wr_stb, // write strobe
  input wire pcs_byte_t rd_data // read data for reg_addr
);
  // ==========
  // bus condition detect
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, start_c, stop_c;
  pcs_slave_state_e state;
  pcs_phase_e phase;
  logic [3:0] bit_cnt;
  pcs_byte_t shreg;
  logic rw;

  // previous pin levels for edge detect
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  assign scl_rise = ~scl_q & scl_i;
  assign scl_fall = scl_q & ~scl_i;
  assign start_c = scl_q & scl_i & sda_q & ~sda_i;
  assign stop_c = scl_q & scl_i & ~sda_q & sda_i;
  assign sda_o = 1'b0; // open drain: only pulls low
  assign wr_data = shreg;

  // ==========
  // byte engine; pointer auto-increments per byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SL_IDLE;
      phase <= PH_ADDR;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      sda_oe <= 1'b0;
      reg_addr <= 8'h00;
      wr_stb <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (start_c) begin
        state <= SL_RX;
        phase <= PH_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        state <= SL_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          SL_RX: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_i};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              case (phase)
                PH_ADDR: begin
                  // other addresses: stay silent until next start
                  if (shreg[7:1] == DEV_ADDR) begin
                    rw <= shreg[0];
                    sda_oe <= 1'b1;
                    state <= SL_ACK;
                  end else begin
                    state <= SL_IDLE;
                  end
                end
                PH_PTR: begin
                  reg_addr <= shreg;
                  sda_oe <= 1'b1;
                  state <= SL_ACK;
                end
                default: begin
                  wr_stb <= 1'b1;
                  sda_oe <= 1'b1;
                  state <= SL_ACK;
                end
              endcase
            end
          end
          SL_ACK: begin
            if (scl_fall) begin
              if (phase == PH_ADDR && rw) begin
                shreg <= rd_data;
                sda_oe <= ~rd_data[7];
                state <= SL_TX;
              end else begin
                sda_oe <= 1'b0;
                state <= SL_RX;
                if (phase == PH_DATA) begin
                  reg_addr <= reg_addr + 8'h01;
                end
                phase <= (phase == PH_ADDR) ? PH_PTR : PH_DATA;
              end
            end
          end
          SL_TX: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                sda_oe <= 1'b0;
                bit_cnt <= 4'h0;
                reg_addr <= reg_addr + 8'h01;
                state <= SL_RACK;
              end else begin
                shreg <= {shreg[6:0], 1'b0};
                sda_oe <= ~shreg[6];
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          SL_RACK: begin
            // a nack from the master ends the read
            if (scl_rise && sda_i) begin
              state <= SL_IDLE;
            end else if (scl_fall) begin
              shreg <= rd_data;
              sda_oe <= ~rd_data[7];
              state <= SL_TX;
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule : pcs_i2c_slave

/* File: hw/pcs_protection_regs.sv */
`timescale 1ns/1ps
`include "pcs_consts.svh"
// Summary of operation
// - Configuration writes take effect only while the lock register does not hold the key value.
// - The sum overcurrent delay code selects 112, 56 (reset), 28 or 14 microseconds.
// - The sum overcurrent limit is 2.2V plus or minus the five-bit code times 50mV by the direction bit.
// - The absolute overvoltage code selects 2V (reset), 1.8V, 2.2V or 2.4V.
// - The relative overvoltage code selects 150% (reset), 140%, 130% or 120% of reference.
// - The undervoltage code selects 40% (reset), 30%, 50% or 60% of reference.
// - The over-temperature code selects 150C (reset), 160C, 170C or 140C.
// - Five disable bits, external temp, over-temp, sum overcurrent, undervoltage, overvoltage; 1 disables.
// - Five read-only fault flags in the same order read 1 once that protection has triggered.
// - Eight read-only phase overcurrent flags, bit n-1 for phase n.
// - Phase flags update only while the phase enable bit is 1, otherwise they read zero.
module pcs_protection_regs import pcs_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = `PCS_I2C_ADDR,
  parameter int CLK_MHZ = `PCS_CLK_MHZ,
  parameter int SOC_DLY0_CYC = `PCS_SOC_DLY0_US * CLK_MHZ,
  parameter int SOC_DLY1_CYC = `PCS_SOC_DLY1_US * CLK_MHZ,
  parameter int SOC_DLY2_CYC = `PCS_SOC_DLY2_US * CLK_MHZ,
  parameter int SOC_DLY3_CYC = `PCS_SOC_DLY3_US * CLK_MHZ
) (
  input wire logic sys_clk, // 40 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic scl_i, // serial clock pin
  input wire logic sda_i, // serial data pin level
  output logic sda_o, // serial data drive value
  output logic sda_oe, // serial data drive enable
  input wire logic [4:0] protection_raw, // comparator hits, bit order as flags
  input wire logic [7:0] phase_overcurrent_raw, // per-phase overcurrent hits
  output logic [4:0] protection_enable, // per-protection enables
  output logic [4:0] protection_tripped, // sticky fault flags
  output logic [7:0] phase_overcurrent_tripped, // sticky phase flags
  output logic [11:0] sum_overcurrent_limit_mv, // sum overcurrent limit
  output logic [11:0] overvoltage_abs_mv, // absolute overvoltage level
  output logic [7:0] overvoltage_rel_pct, // relative overvoltage level
  output logic [7:0] undervoltage_pct, // undervoltage level
  output logic [7:0] overtemp_degc // over-temperature level
);
  // ==========
  // host access
  pcs_byte_t reg_addr, wr_data, rd_data;
  logic wr_stb, cfg_wr_ok;
  logic [7:0] lock_reg;
  logic [1:0] soc_delay_reg, ovp_abs_reg, ovp_rel_reg, uvp_reg, otp_reg;
  logic [5:0] soc_adjust_reg;
  logic [4:0] disable_reg, fault_flags_reg, fault_hit;
  logic [7:0] phase_flags_reg;
  logic phase_en_reg;
  logic [12:0] soc_cnt_reg;
  logic [12:0] soc_target;
  logic soc_trip;
  // code-indexed decode tables
  localparam logic [11:0] ABS_TAB [4] = '{`PCS_OVP_ABS_MV0, `PCS_OVP_ABS_MV1, `PCS_OVP_ABS_MV2, `PCS_OVP_ABS_MV3};
  localparam logic [7:0] REL_TAB [4] = '{`PCS_OVP_REL_PCT0, `PCS_OVP_REL_PCT1, `PCS_OVP_REL_PCT2, `PCS_OVP_REL_PCT3};
  localparam logic [7:0] UV_TAB [4] = '{`PCS_UVP_PCT0, `PCS_UVP_PCT1, `PCS_UVP_PCT2, `PCS_UVP_PCT3};
  localparam logic [7:0] OT_TAB [4] = '{`PCS_OTP_DEGC0, `PCS_OTP_DEGC1, `PCS_OTP_DEGC2, `PCS_OTP_DEGC3};
  localparam int DLY_TAB [4] = '{SOC_DLY0_CYC, SOC_DLY1_CYC, SOC_DLY2_CYC, SOC_DLY3_CYC};

  pcs_i2c_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_slave (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .wr_stb(wr_stb),
    .rd_data(rd_data)
  );

  // key value freezes every setting; the lock itself stays writable
  assign cfg_wr_ok = (lock_reg != `PCS_LOCK_KEY);

  // sum limit arithmetic, shared by the output register
  function automatic logic [11:0] soc_limit(input logic [5:0] adj);
    logic [11:0] delta;
    delta = 12'(adj[4:0]) * `PCS_SOC_STEP_MV;
    if (adj[`PCS_SOC_DIR_BIT]) begin
      soc_limit = `PCS_SOC_BASE_MV - delta;
    end else begin
      soc_limit = `PCS_SOC_BASE_MV + delta;
    end
  endfunction : soc_limit

  // ==========
  // lock register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg <= `PCS_RST_LOCK;
    end else if (wr_stb && reg_addr == `PCS_OFS_LOCK) begin
      lock_reg <= wr_data;
    end
  end

  // ==========
  // configuration registers, refused while locked
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      soc_delay_reg <= `PCS_RST_SOC_DELAY;
      soc_adjust_reg <= `PCS_RST_SOC_ADJUST;
      ovp_abs_reg <= `PCS_RST_TWO_BIT;
      ovp_rel_reg <= `PCS_RST_TWO_BIT;
      uvp_reg <= `PCS_RST_TWO_BIT;
      otp_reg <= `PCS_RST_TWO_BIT;
      disable_reg <= `PCS_RST_DISABLE;
      phase_en_reg <= `PCS_RST_PHASE_EN;
    end else if (wr_stb && cfg_wr_ok) begin
      if (reg_addr == `PCS_OFS_SOC_DELAY) begin
        soc_delay_reg <= wr_data[1:0];
      end else if (reg_addr == `PCS_OFS_SOC_ADJUST) begin
        soc_adjust_reg <= wr_data[5:0];
      end else if (reg_addr == `PCS_OFS_OVP_ABS) begin
        ovp_abs_reg <= wr_data[1:0];
      end else if (reg_addr == `PCS_OFS_OVP_REL) begin
        ovp_rel_reg <= wr_data[1:0];
      end else if (reg_addr == `PCS_OFS_UVP) begin
        uvp_reg <= wr_data[1:0];
      end else if (reg_addr == `PCS_OFS_OTP) begin
        otp_reg <= wr_data[1:0];
      end else if (reg_addr == `PCS_OFS_DISABLE) begin
        disable_reg <= wr_data[4:0];
      end else if (reg_addr == `PCS_OFS_PHASE_EN) begin
        phase_en_reg <= wr_data[0];
      end
    end
  end

  // ==========
  // read mux; unmapped offsets read zero
  always_comb begin
    rd_data = 8'h00;
    if (reg_addr == `PCS_OFS_LOCK) begin
      rd_data = lock_reg;
    end else if (reg_addr == `PCS_OFS_SOC_DELAY) begin
      rd_data = {6'h00, soc_delay_reg};
    end else if (reg_addr == `PCS_OFS_SOC_ADJUST) begin
      rd_data = {2'h0, soc_adjust_reg};
    end else if (reg_addr == `PCS_OFS_OVP_ABS) begin
      rd_data = {6'h00, ovp_abs_reg};
    end else if (reg_addr == `PCS_OFS_OVP_REL) begin
      rd_data = {6'h00, ovp_rel_reg};
    end else if (reg_addr == `PCS_OFS_UVP) begin
      rd_data = {6'h00, uvp_reg};
    end else if (reg_addr == `PCS_OFS_OTP) begin
      rd_data = {6'h00, otp_reg};
    end else if (reg_addr == `PCS_OFS_DISABLE) begin
      rd_data = {3'h0, disable_reg};
    end else if (reg_addr == `PCS_OFS_FAULT_FLAGS) begin
      rd_data = {3'h0, fault_flags_reg};
    end else if (reg_addr == `PCS_OFS_PHASE_FLAGS) begin
      rd_data = phase_flags_reg;
    end else if (reg_addr == `PCS_OFS_PHASE_EN) begin
      rd_data = {7'h00, phase_en_reg};
    end
  end

  // ==========
  // sum overcurrent debounce delay
  always_comb begin
    soc_target = 13'(DLY_TAB[soc_delay_reg]);
  end

  // the comparator must stay high the whole delay; any drop restarts it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      soc_cnt_reg <= 13'h0000;
    end else if (!protection_raw[`PCS_BIT_SOC]) begin
      soc_cnt_reg <= 13'h0000;
    end else if (soc_cnt_reg < soc_target) begin
      soc_cnt_reg <= soc_cnt_reg + 13'h0001;
    end
  end

  assign soc_trip = protection_raw[`PCS_BIT_SOC] && (soc_cnt_reg >= soc_target);

  // only the sum overcurrent hit goes through the delay filter
  always_comb begin
    fault_hit = protection_raw;
    fault_hit[`PCS_BIT_SOC] = soc_trip;
  end

  // ==========
  // sticky fault flags; disabled protections never trip
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_flags_reg <= 5'h00;
    end else begin
      fault_flags_reg <= fault_flags_reg | (fault_hit & ~disable_reg);
    end
  end

  // phase flags are held at zero while their enable is off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_flags_reg <= 8'h00;
    end else if (!phase_en_reg) begin
      phase_flags_reg <= 8'h00;
    end else begin
      phase_flags_reg <= phase_flags_reg | phase_overcurrent_raw;
    end
  end

  // ==========
  // decoded settings towards the analog side
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_overcurrent_limit_mv <= `PCS_SOC_BASE_MV;
      overvoltage_abs_mv <= `PCS_OVP_ABS_MV0;
      overvoltage_rel_pct <= `PCS_OVP_REL_PCT0;
      undervoltage_pct <= `PCS_UVP_PCT0;
      overtemp_degc <= `PCS_OTP_DEGC0;
    end else begin
      sum_overcurrent_limit_mv <= soc_limit(soc_adjust_reg);
      overvoltage_abs_mv <= ABS_TAB[ovp_abs_reg];
      overvoltage_rel_pct <= REL_TAB[ovp_rel_reg];
      undervoltage_pct <= UV_TAB[uvp_reg];
      overtemp_degc <= OT_TAB[otp_reg];
    end
  end

  // enables and flags leave on registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      protection_enable <= 5'h1F;
      protection_tripped <= 5'h00;
      phase_overcurrent_tripped <= 8'h00;
    end else begin
      protection_enable <= ~disable_reg;
      protection_tripped <= fault_flags_reg;
      phase_overcurrent_tripped <= phase_flags_reg;
    end
  end
endmodule : pcs_protection_regs

/* File: pkg/pcs_consts.svh */
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
// ==========
// register offsets
`define PCS_OFS_LOCK 8'h00
`define PCS_OFS_SOC_DELAY 8'h23
`define PCS_OFS_SOC_ADJUST 8'h24
`define PCS_OFS_OVP_ABS 8'h25
`define PCS_OFS_OVP_REL 8'h26
`define PCS_OFS_UVP 8'h27
`define PCS_OFS_OTP 8'h28
`define PCS_OFS_DISABLE 8'h29
`define PCS_OFS_FAULT_FLAGS 8'h2A
`define PCS_OFS_PHASE_FLAGS 8'h2B
`define PCS_OFS_PHASE_EN 8'h4D
// ==========
// reset values and key
`define PCS_LOCK_KEY 8'hA6
`define PCS_RST_LOCK 8'h00
`define PCS_RST_SOC_DELAY 2'h1
`define PCS_RST_SOC_ADJUST 6'h00
`define PCS_RST_TWO_BIT 2'h0
`define PCS_RST_DISABLE 5'h00
`define PCS_RST_PHASE_EN 1'h0
// ==========
// field positions
`define PCS_SOC_DIR_BIT 5
`define PCS_BIT_EXT_TEMP 4
`define PCS_BIT_OTP 3
`define PCS_BIT_SOC 2
`define PCS_BIT_UVP 1
`define PCS_BIT_OVP 0
// ==========
// thresholds (mV, percent, degC)
`define PCS_SOC_BASE_MV 12'h898
`define PCS_SOC_STEP_MV 12'h032
`define PCS_OVP_ABS_MV0 12'h7D0
`define PCS_OVP_ABS_MV1 12'h708
`define PCS_OVP_ABS_MV2 12'h898
`define PCS_OVP_ABS_MV3 12'h960
`define PCS_OVP_REL_PCT0 8'h96
`define PCS_OVP_REL_PCT1 8'h8C
`define PCS_OVP_REL_PCT2 8'h82
`define PCS_OVP_REL_PCT3 8'h78
`define PCS_UVP_PCT0 8'h28
`define PCS_UVP_PCT1 8'h1E
`define PCS_UVP_PCT2 8'h32
`define PCS_UVP_PCT3 8'h3C
`define PCS_OTP_DEGC0 8'h96
`define PCS_OTP_DEGC1 8'hA0
`define PCS_OTP_DEGC2 8'hAA
`define PCS_OTP_DEGC3 8'h8C
// ==========
// timing
`define PCS_CLK_MHZ 40
`define PCS_SOC_DLY0_US 112
`define PCS_SOC_DLY1_US 56
`define PCS_SOC_DLY2_US 28
`define PCS_SOC_DLY3_US 14
`define PCS_I2C_ADDR 7'h20
`endif

/* File: pkg/pcs_pkg.sv */
package pcs_pkg;
  // ==========
  // serial slave types
  typedef enum logic [2:0] {SL_IDLE, SL_RX, SL_ACK, SL_TX, SL_RACK} pcs_slave_state_e;
  typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA} pcs_phase_e;
  typedef logic [7:0] pcs_byte_t;
endpackage : pcs_pkg
